/* File: hw/pme_route_regs.svh */
`ifndef PME_ROUTE_REGS_SVH
`define PME_ROUTE_REGS_SVH

// ****************************************
// configuration space layout of one root port function
// ****************************************
`define PCIE_CAP_BASE 8'h40
`define ROOT_CTRL_CAP_OFS 8'h1c
`define ROOT_STATUS_CAP_OFS 8'h20
`define MISC_PORT_CONFIG_OFS 8'hd8
`define PWR_MGMT_CTRL_STATUS_OFS 8'hdc

// ****************************************
// field positions
// ****************************************
`define ROOT_CTRL_PME_INT_EN_BIT 3
`define ROOT_STATUS_PME_STATUS_BIT 16
`define ROOT_STATUS_PME_PENDING_BIT 17
`define MPC_SCI_ROUTE_BIT 31
`define MPC_SMI_ROUTE_BIT 0
`define POWER_MGMT_CTRL_STATUS_PME_EN_BIT 8
`define POWER_MGMT_CTRL_STATUS_PME_STATUS_BIT 31

// ****************************************
// general purpose event block
// ****************************************
`define GENERAL_EVENT_STATUS_OFS 4'h0
`define GENERAL_EVENT_ENABLE_OFS 4'h4
`define GENERAL_EVENT_PCIE_BIT 17

// ****************************************
// reset values
// ****************************************
`define ROOT_CTRL_RESET 32'h0000_0000
`define MISC_PORT_CONFIG_RESET 32'h0000_0000
`define POWER_MGMT_CTRL_STATUS_RESET 32'h0000_0000
`define GENERAL_EVENT_RESET 32'h0000_0000

`endif

/* File: hw/pme_route_pkg.sv */
package pme_route_pkg;

  typedef logic [15:0] requester_id_t;
  typedef logic [31:0] cfg_word_t;

  // where a latched port event is delivered
  typedef enum logic [1:0] {
    route_native,
    route_sci,
    route_smi,
    route_sci_smi
  } pme_route_t;

endpackage : pme_route_pkg

/* File: hw/pme_event_latch.sv */
`timescale 1ns/1ns
module pme_event_latch
  import pme_route_pkg::*;
(
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic msg_valid_i,
  input wire requester_id_t msg_req_id_i,
  input wire logic clear_i,
  output logic status_o,
  output logic pending_o,
  output requester_id_t req_id_o
);

  logic status;
  logic pending;
  requester_id_t req_id;
  requester_id_t pend_id;
  logic next_status;
  logic next_pending;
  requester_id_t next_req_id;
  requester_id_t next_pend_id;

  // ****************************************
  // status, requester and one-deep pending slot
  // ****************************************
  always_comb
  begin
    next_status = status;
    next_pending = pending;
    next_req_id = req_id;
    next_pend_id = pend_id;
    if (clear_i && status)
    begin
      if (pending)
      begin
        // a queued message re-arms the status bit at once
        next_status = 1'b1;
        next_req_id = pend_id;
        next_pending = msg_valid_i;
        next_pend_id = msg_req_id_i;
      end
      else if (msg_valid_i)
      begin
        // arrival in the clearing cycle wins over the clear
        next_status = 1'b1;
        next_req_id = msg_req_id_i;
      end
      else
      begin
        next_status = 1'b0;
      end
    end
    else if (msg_valid_i)
    begin
      if (!status)
      begin
        next_status = 1'b1;
        next_req_id = msg_req_id_i;
      end
      else if (!pending)
      begin
        next_pending = 1'b1;
        next_pend_id = msg_req_id_i;
      end
      // a third message while the slot is full is dropped; the ids kept are the oldest
    end
  end

  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      status <= 1'b0;
      pending <= 1'b0;
      req_id <= 16'h0000;
      pend_id <= 16'h0000;
    end
    else
    begin
      status <= next_status;
      pending <= next_pending;
      req_id <= next_req_id;
      pend_id <= next_pend_id;
    end
  end

  assign status_o = status;
  assign pending_o = pending;
  assign req_id_o = req_id;

endmodule : pme_event_latch

/* File: hw/pme_route.sv */
`timescale 1ns/1ns
`include "pme_route_regs.svh"
module pme_route
  import pme_route_pkg::*;
(
  input wire logic mclk_i,
  input wire logic reset_i,
  // in-band PME messages from the link layer, same clock
  input wire logic pme_msg_valid_i,
  input wire logic pme_msg_port_i,
  input wire requester_id_t pme_msg_req_id_i,
  // configuration access to the two root port functions
  input wire logic cfg_func_i,
  input wire logic [7:0] cfg_addr_i,
  input wire logic cfg_wr_i,
  input wire logic cfg_rd_i,
  input wire cfg_word_t cfg_wdata_i,
  output cfg_word_t cfg_rdata_o,
  output logic cfg_rvalid_o,
  // general purpose event block access
  input wire logic [3:0] gpe_addr_i,
  input wire logic gpe_wr_i,
  input wire logic gpe_rd_i,
  input wire cfg_word_t gpe_wdata_i,
  output cfg_word_t gpe_rdata_o,
  output logic gpe_rvalid_o,
  // event outputs
  output logic native_int_o,
  output logic sci_o,
  output logic smi_o
);

  localparam int unsigned NPORTS = 2;

  // ****************************************
  // register addresses
  // ****************************************
  localparam logic [7:0] ROOT_CTRL_ADDR = `PCIE_CAP_BASE + `ROOT_CTRL_CAP_OFS;
  localparam logic [7:0] ROOT_STATUS_ADDR = `PCIE_CAP_BASE + `ROOT_STATUS_CAP_OFS;

  // ****************************************
  // per-port state
  // ****************************************
  logic [NPORTS-1:0] pme_int_en;
  logic [NPORTS-1:0] sci_route;
  logic [NPORTS-1:0] smi_route;
  logic [NPORTS-1:0] power_mgmt_ctrl_status_pme_en;
  logic [NPORTS-1:0] power_mgmt_ctrl_status_pme_status;
  logic [NPORTS-1:0] next_power_mgmt_ctrl_status_pme_status;

  logic [NPORTS-1:0] port_msg;
  logic [NPORTS-1:0] root_clear;
  logic [NPORTS-1:0] power_mgmt_ctrl_status_clear;
  logic [NPORTS-1:0] root_status;
  logic [NPORTS-1:0] root_pending;
  requester_id_t port_req_id [NPORTS];
  pme_route_t port_route [NPORTS];

  // ****************************************
  // event block state
  // ****************************************
  logic gpe_pcie_status;
  logic gpe_pcie_enable;
  logic next_gpe_pcie_status;

  // ****************************************
  // access decode
  // ****************************************
  wire hit_root_ctrl = cfg_addr_i == ROOT_CTRL_ADDR;
  wire hit_root_status = cfg_addr_i == ROOT_STATUS_ADDR;
  wire hit_mpc = cfg_addr_i == `MISC_PORT_CONFIG_OFS;
  wire hit_power_mgmt_ctrl_status = cfg_addr_i == `PWR_MGMT_CTRL_STATUS_OFS;
  wire hit_gpe_status = gpe_addr_i == `GENERAL_EVENT_STATUS_OFS;
  wire hit_gpe_enable = gpe_addr_i == `GENERAL_EVENT_ENABLE_OFS;

  wire gpe_status_w1c = gpe_wr_i && hit_gpe_status &&
    gpe_wdata_i[`GENERAL_EVENT_PCIE_BIT];

  // a port accepts a message only while its power management enable is set
  wire [NPORTS-1:0] port_sci_event = port_msg & sci_route;

  // ****************************************
  // per-port logic
  // ****************************************
  genvar p;
  generate
    for (p = 0; p < NPORTS; p++)
    begin : g_port
      wire sel = cfg_func_i == 1'(p);
      wire wr_root_ctrl = cfg_wr_i && sel && hit_root_ctrl;
      wire wr_mpc = cfg_wr_i && sel && hit_mpc;
      wire wr_power_mgmt_ctrl_status = cfg_wr_i && sel && hit_power_mgmt_ctrl_status;

      assign port_msg[p] = pme_msg_valid_i && (pme_msg_port_i == 1'(p)) &&
        power_mgmt_ctrl_status_pme_en[p];

      assign root_clear[p] = cfg_wr_i && sel && hit_root_status &&
        cfg_wdata_i[`ROOT_STATUS_PME_STATUS_BIT];

      assign power_mgmt_ctrl_status_clear[p] = cfg_wr_i && sel && hit_power_mgmt_ctrl_status &&
        cfg_wdata_i[`POWER_MGMT_CTRL_STATUS_PME_STATUS_BIT];

      assign port_route[p] = pme_route_t'({smi_route[p], sci_route[p]});

      // the new event wins when it lands in the clearing cycle
      assign next_power_mgmt_ctrl_status_pme_status[p] = port_msg[p] ||
        (power_mgmt_ctrl_status_pme_status[p] && !power_mgmt_ctrl_status_clear[p]);

      pme_event_latch u_latch (
        .mclk_i(mclk_i),
        .reset_i(reset_i),
        .msg_valid_i(port_msg[p]),
        .msg_req_id_i(pme_msg_req_id_i),
        .clear_i(root_clear[p]),
        .status_o(root_status[p]),
        .pending_o(root_pending[p]),
        .req_id_o(port_req_id[p])
      );

      // one short process per register; writes to other offsets leave it alone
      always_ff @(posedge mclk_i or posedge reset_i)
      begin
        if (reset_i)
        begin
          pme_int_en[p] <= 1'(`ROOT_CTRL_RESET >> `ROOT_CTRL_PME_INT_EN_BIT);
        end
        else if (wr_root_ctrl)
        begin
          pme_int_en[p] <= cfg_wdata_i[`ROOT_CTRL_PME_INT_EN_BIT];
        end
      end

      always_ff @(posedge mclk_i or posedge reset_i)
      begin
        if (reset_i)
        begin
          sci_route[p] <= 1'(`MISC_PORT_CONFIG_RESET >> `MPC_SCI_ROUTE_BIT);
          smi_route[p] <= 1'(`MISC_PORT_CONFIG_RESET >> `MPC_SMI_ROUTE_BIT);
        end
        else if (wr_mpc)
        begin
          sci_route[p] <= cfg_wdata_i[`MPC_SCI_ROUTE_BIT];
          smi_route[p] <= cfg_wdata_i[`MPC_SMI_ROUTE_BIT];
        end
      end

      // an enable written in the cycle of a message only acts from the next cycle
      always_ff @(posedge mclk_i or posedge reset_i)
      begin
        if (reset_i)
        begin
          power_mgmt_ctrl_status_pme_en[p] <= 1'(`POWER_MGMT_CTRL_STATUS_RESET >> `POWER_MGMT_CTRL_STATUS_PME_EN_BIT);
          power_mgmt_ctrl_status_pme_status[p] <= 1'b0;
        end
        else
        begin
          if (wr_power_mgmt_ctrl_status)
          begin
            power_mgmt_ctrl_status_pme_en[p] <= cfg_wdata_i[`POWER_MGMT_CTRL_STATUS_PME_EN_BIT];
          end
          power_mgmt_ctrl_status_pme_status[p] <= next_power_mgmt_ctrl_status_pme_status[p];
        end
      end
    end
  endgenerate

  // ****************************************
  // event block: PCIE status bit and its enable
  // ****************************************
  // set wins over the write-one-clear so a PME racing the handler is kept
  assign next_gpe_pcie_status = (|port_sci_event) ||
    (gpe_pcie_status && !gpe_status_w1c);

  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      gpe_pcie_status <= 1'b0;
      gpe_pcie_enable <= 1'(`GENERAL_EVENT_RESET >> `GENERAL_EVENT_PCIE_BIT);
    end
    else
    begin
      gpe_pcie_status <= next_gpe_pcie_status;
      if (gpe_wr_i && hit_gpe_enable)
      begin
        gpe_pcie_enable <= gpe_wdata_i[`GENERAL_EVENT_PCIE_BIT];
      end
    end
  end

  // ****************************************
  // event outputs
  // ****************************************
  logic [NPORTS-1:0] port_native;
  logic [NPORTS-1:0] port_smi;

  always_comb
  begin
    port_native = '0;
    port_smi = '0;
    for (int i = 0; i < NPORTS; i++)
    begin
      case (port_route[i])
        route_native:
        begin
          // native delivery only when the port is handed to neither the event block nor smi
          port_native[i] = root_status[i] && pme_int_en[i];
        end
        route_sci:
        begin
          port_native[i] = 1'b0;
        end
        route_smi:
        begin
          port_smi[i] = root_status[i];
        end
        route_sci_smi:
        begin
          port_smi[i] = root_status[i];
        end
        default:
        begin
          port_native[i] = 1'b0;
        end
      endcase
    end
  end

  // levels, not pulses: they fall only when software clears the cause, its enable or its route
  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      native_int_o <= 1'b0;
      smi_o <= 1'b0;
      sci_o <= 1'b0;
    end
    else
    begin
      native_int_o <= |port_native;
      smi_o <= |port_smi;
      sci_o <= next_gpe_pcie_status && gpe_pcie_enable;
    end
  end

  // there is deliberately no wake pin input; wake is handled elsewhere

  // ****************************************
  // read data
  // ****************************************
  cfg_word_t cfg_read_word;
  cfg_word_t gpe_read_word;
  logic fsel;

  always_comb
  begin
    fsel = cfg_func_i;
    cfg_read_word = 32'h0000_0000;
    if (hit_root_ctrl)
    begin
      cfg_read_word[`ROOT_CTRL_PME_INT_EN_BIT] = pme_int_en[fsel];
    end
    else if (hit_root_status)
    begin
      cfg_read_word[15:0] = port_req_id[fsel];
      cfg_read_word[`ROOT_STATUS_PME_STATUS_BIT] = root_status[fsel];
      cfg_read_word[`ROOT_STATUS_PME_PENDING_BIT] = root_pending[fsel];
    end
    else if (hit_mpc)
    begin
      cfg_read_word[`MPC_SCI_ROUTE_BIT] = sci_route[fsel];
      cfg_read_word[`MPC_SMI_ROUTE_BIT] = smi_route[fsel];
    end
    else if (hit_power_mgmt_ctrl_status)
    begin
      cfg_read_word[`POWER_MGMT_CTRL_STATUS_PME_EN_BIT] = power_mgmt_ctrl_status_pme_en[fsel];
      cfg_read_word[`POWER_MGMT_CTRL_STATUS_PME_STATUS_BIT] = power_mgmt_ctrl_status_pme_status[fsel];
    end
  end

  always_comb
  begin
    gpe_read_word = 32'h0000_0000;
    if (hit_gpe_status)
    begin
      gpe_read_word[`GENERAL_EVENT_PCIE_BIT] = gpe_pcie_status;
    end
    else if (hit_gpe_enable)
    begin
      gpe_read_word[`GENERAL_EVENT_PCIE_BIT] = gpe_pcie_enable;
    end
  end

  // read data stands until the next read, so a slow master may pick it up late
  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      cfg_rdata_o <= 32'h0000_0000;
      cfg_rvalid_o <= 1'b0;
    end
    else
    begin
      cfg_rvalid_o <= cfg_rd_i;
      if (cfg_rd_i)
      begin
        cfg_rdata_o <= cfg_read_word;
      end
    end
  end

  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      gpe_rdata_o <= 32'h0000_0000;
      gpe_rvalid_o <= 1'b0;
    end
    else
    begin
      gpe_rvalid_o <= gpe_rd_i;
      if (gpe_rd_i)
      begin
        gpe_rdata_o <= gpe_read_word;
      end
    end
  end

endmodule : pme_route

/* File: dv/pme_route_props.sv */
`timescale 1ns/1ns
// ****************************************
// port checks of pme routing
// ****************************************
module pme_route_props
  import pme_route_pkg::*;
(
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic pme_msg_valid_i,
  input wire logic cfg_wr_i,
  input wire logic cfg_rd_i,
  input wire cfg_word_t cfg_rdata_o,
  input wire logic cfg_rvalid_o,
  input wire logic [3:0] gpe_addr_i,
  input wire logic gpe_wr_i,
  input wire logic gpe_rd_i,
  input wire cfg_word_t gpe_wdata_i,
  input wire logic gpe_rvalid_o,
  input wire logic native_int_o,
  input wire logic sci_o,
  input wire logic smi_o
);
  default clocking @(posedge mclk_i);
  endclocking
  default disable iff (reset_i);
  cfg_answer_a: assert property (cfg_rvalid_o == $past(cfg_rd_i))
    else $error("config read answer off its cycle");
  event_answer_a: assert property (gpe_rvalid_o == $past(gpe_rd_i))
    else $error("event read answer off its cycle");
  read_data_hold_a: assert property (!cfg_rvalid_o |-> $stable(cfg_rdata_o))
    else $error("config read data moved without a read");
  native_cause_a: assert property (
    $rose(native_int_o) |-> $past(pme_msg_valid_i) || $past(pme_msg_valid_i, 2)
    || $past(cfg_wr_i) || $past(cfg_wr_i, 2)) else $error("native interrupt without cause");
  native_hold_a: assert property (
    native_int_o && !cfg_wr_i && !$past(cfg_wr_i) |=> native_int_o)
    else $error("native interrupt dropped without a write");
  smi_hold_a: assert property (
    smi_o && !cfg_wr_i && !$past(cfg_wr_i) |=> smi_o) else $error("smi dropped without a write");
  smi_cause_a: assert property (
    $rose(smi_o) |-> $past(pme_msg_valid_i) || $past(pme_msg_valid_i, 2)
    || $past(cfg_wr_i) || $past(cfg_wr_i, 2)) else $error("smi without cause");
  sci_clear_a: assert property (
    gpe_wr_i && gpe_addr_i == 4'h0 && gpe_wdata_i[17] && !pme_msg_valid_i ##1
    !pme_msg_valid_i |=> !sci_o) else $error("sci kept after status clear");
  sci_hold_a: assert property (
    sci_o && !gpe_wr_i && !$past(gpe_wr_i) |=> sci_o) else $error("sci dropped without a write");
endmodule : pme_route_props

bind pme_route pme_route_props chk_u (
  .mclk_i(mclk_i), .reset_i(reset_i), .pme_msg_valid_i(pme_msg_valid_i),
  .cfg_wr_i(cfg_wr_i), .cfg_rd_i(cfg_rd_i), .cfg_rdata_o(cfg_rdata_o),
  .cfg_rvalid_o(cfg_rvalid_o), .gpe_addr_i(gpe_addr_i), .gpe_wr_i(gpe_wr_i),
  .gpe_rd_i(gpe_rd_i), .gpe_wdata_i(gpe_wdata_i), .gpe_rvalid_o(gpe_rvalid_o),
  .native_int_o(native_int_o), .sci_o(sci_o), .smi_o(smi_o)
);

/* File: dv/pme_sender.sv */
`timescale 1ns/1ns
// ****************************************
// downstream devices sending pme messages
// ****************************************
module pme_sender
  import pme_route_pkg::*;
(
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic req_i,
  input wire logic req_port_i,
  input wire requester_id_t req_id_i,
  input wire logic [3:0] wait_i,
  output logic msg_valid_o,
  output logic msg_port_o,
  output requester_id_t msg_req_id_o
);
  logic armed;
  logic [3:0] cnt;
  logic port_q;
  requester_id_t id_q;
  // idle lines show the inverse of the last message, never a stale copy
  assign msg_port_o = msg_valid_o ? port_q : ~port_q;
  assign msg_req_id_o = msg_valid_o ? id_q : ~id_q;
  // one pulse per message after a chosen wait; devices have no wake line here
  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      armed <= 1'b0;
      cnt <= 4'h0;
      port_q <= 1'b0;
      id_q <= 16'h0;
      msg_valid_o <= 1'b0;
    end
    else
    begin
      msg_valid_o <= armed && cnt == 4'h0;
      if (req_i)
      begin
        armed <= 1'b1;
        cnt <= wait_i;
        port_q <= req_port_i;
        id_q <= req_id_i;
      end
      else if (armed && cnt == 4'h0)
        armed <= 1'b0;
      else if (armed)
        cnt <= cnt - 4'h1;
    end
  end
endmodule : pme_sender

/* File: dv/pme_route_tb.sv */
`timescale 1ns/1ns
// ****************************************
// pme routing bench
// ****************************************
module pme_route_tb
  import pme_route_pkg::*;
;
  logic mclk_i = 1'b0;
  logic reset_i = 1'b1;
  logic rq = 1'b0, rq_port = 1'b0, func = 1'b0, cwr = 1'b0, crd = 1'b0, gwr = 1'b0, grd = 1'b0;
  logic [3:0] rq_wait = 4'h0;
  logic [7:0] addr = 8'h0;
  requester_id_t rq_id = 16'h0, id, id1, id2;
  cfg_word_t wdata = 32'h0, crdata, grdata;
  logic valid, port, crv, grv, native, sci, smi;
  logic [7:0] regs [4] = '{8'h5c, 8'h60, 8'hd8, 8'hdc};
  int n_fail = 0, num_checks = 0, cycles = 0, i;
  bit p;

  initial
  begin
    forever #50 mclk_i = ~mclk_i;
  end

  pme_sender dev_u (.mclk_i(mclk_i), .reset_i(reset_i), .req_i(rq), .req_port_i(rq_port),
    .req_id_i(rq_id), .wait_i(rq_wait), .msg_valid_o(valid), .msg_port_o(port),
    .msg_req_id_o(id));
  pme_route dut_u (.mclk_i(mclk_i), .reset_i(reset_i), .pme_msg_valid_i(valid),
    .pme_msg_port_i(port), .pme_msg_req_id_i(id), .cfg_func_i(func), .cfg_addr_i(addr),
    .cfg_wr_i(cwr), .cfg_rd_i(crd), .cfg_wdata_i(wdata), .cfg_rdata_o(crdata),
    .cfg_rvalid_o(crv), .gpe_addr_i(addr[3:0]), .gpe_wr_i(gwr), .gpe_rd_i(grd),
    .gpe_wdata_i(wdata), .gpe_rdata_o(grdata), .gpe_rvalid_o(grv), .native_int_o(native),
    .sci_o(sci), .smi_o(smi));

  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : complete_run

  // the run needs well under 3000 cycles; a hang ends here
  always @(posedge mclk_i)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      n_fail++;
      complete_run();
    end
  end

  function automatic cfg_word_t flag(input logic x);
    return {31'h0, x};
  endfunction : flag

  function automatic cfg_word_t root(input logic [1:0] f, input requester_id_t r);
    return {14'h0, f, r};
  endfunction : root

  task automatic check(input string what, input cfg_word_t seen, input cfg_word_t exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // one transfer on either register port; read data taken with the answer
  task automatic bus(input bit g, input bit w, input bit f, input logic [7:0] a,
    input cfg_word_t d, output cfg_word_t r);
    @(posedge mclk_i);
    #5;
    func = f;
    addr = a;
    wdata = d;
    {gwr, grd, cwr, crd} = {g & w, g & !w, !g & w, !g & !w};
    @(posedge mclk_i);
    #5;
    {gwr, grd, cwr, crd} = 4'h0;
    if (!w)
      check("read answer", flag(g ? grv : crv), 32'h1);
    r = g ? grdata : crdata;
  endtask : bus

  task automatic wr(input bit g, input bit f, input logic [7:0] a, input cfg_word_t d);
    cfg_word_t unused;
    bus(g, 1'b1, f, a, d, unused);
  endtask : wr

  task automatic rd(input string what, input bit g, input bit f, input logic [7:0] a,
    input cfg_word_t m, input cfg_word_t e);
    cfg_word_t v;
    bus(g, 1'b0, f, a, 32'h0, v);
    check(what, v & m, e);
  endtask : rd

  task automatic send(input bit pt, input requester_id_t r, input logic [3:0] w);
    int k;
    @(posedge mclk_i);
    #5;
    {rq, rq_port, rq_id, rq_wait} = {1'b1, pt, r, w};
    @(posedge mclk_i);
    #5;
    rq = 1'b0;
    for (k = 0; k < 20 && valid !== 1'b1; k++)
      @(posedge mclk_i) #5;
    check("message sent", flag(valid), 32'h1);
  endtask : send

  initial
  begin
    void'($urandom(32'h7ce3));
    repeat (6) @(posedge mclk_i);
    #5;
    reset_i = 1'b0;
    for (i = 0; i < 8; i++)
      rd("reset value", 1'b0, i[0], regs[i[2:1]], '1, 32'h0);
    rd("event reset", 1'b1, 1'b0, 8'h0, '1, 32'h0);
    wr(1'b0, 1'b0, 8'h10, '1);
    rd("unmapped", 1'b0, 1'b0, 8'h10, '1, 32'h0);
    for (i = 0; i < 2; i++)
    begin
      wr(1'b0, i[0], 8'hdc, 32'h100);
      wr(1'b0, i[0], 8'h5c, 32'h8);
    end
    for (i = 0; i < 6; i++)
    begin
      p = 1'($urandom);
      id1 = 16'($urandom);
      send(p, id1, 4'($urandom));
      rd("root status", 1'b0, p, 8'h60, '1, root(2'b01, id1));
      check("native", flag(native), 32'h1);
      rd("pm status", 1'b0, p, 8'hdc, '1, 32'h8000_0100);
      wr(1'b0, p, 8'h60, 32'h1_0000);
      wr(1'b0, p, 8'hdc, 32'h8000_0100);
      rd("pm cleared", 1'b0, p, 8'hdc, '1, 32'h100);
      check("native off", flag(native), 32'h0);
    end
    id1 = 16'($urandom);
    id2 = ~id1;
    send(1'b0, id1, 4'h0);
    send(1'b0, id2, 4'h3);
    send(1'b0, 16'h0, 4'h0);
    rd("pending", 1'b0, 1'b0, 8'h60, '1, root(2'b11, id1));
    wr(1'b0, 1'b0, 8'h60, 32'h1_0000);
    rd("reloaded", 1'b0, 1'b0, 8'h60, '1, root(2'b01, id2));
    wr(1'b0, 1'b0, 8'h60, 32'h1_0000);
    rd("drained", 1'b0, 1'b0, 8'h60, 32'h3_0000, 32'h0);
    wr(1'b0, 1'b1, 8'hdc, 32'h0);
    send(1'b1, id1, 4'h0);
    rd("gated", 1'b0, 1'b1, 8'h60, 32'h1_0000, 32'h0);
    // firmware order before sci routing: interrupt off, route, stale status cleared
    wr(1'b0, 1'b1, 8'h5c, 32'h0);
    wr(1'b0, 1'b1, 8'hd8, 32'h8000_0000);
    wr(1'b1, 1'b0, 8'h0, 32'h2_0000);
    wr(1'b1, 1'b0, 8'h4, 32'h2_0000);
    wr(1'b0, 1'b1, 8'hdc, 32'h100);
    send(1'b1, id2, 4'h7);
    rd("event status", 1'b1, 1'b0, 8'h0, 32'h2_0000, 32'h2_0000);
    check("sci", flag(sci), 32'h1);
    check("no native", flag(native), 32'h0);
    // servicing order: event off, port status, event status, event on
    wr(1'b1, 1'b0, 8'h4, 32'h0);
    @(posedge mclk_i) #5;
    check("sci masked", flag(sci), 32'h0);
    wr(1'b0, 1'b1, 8'h60, 32'h1_0000);
    wr(1'b0, 1'b1, 8'hdc, 32'h8000_0100);
    wr(1'b1, 1'b0, 8'h0, 32'h2_0000);
    wr(1'b1, 1'b0, 8'h4, 32'h2_0000);
    rd("event cleared", 1'b1, 1'b0, 8'h0, 32'h2_0000, 32'h0);
    check("sci idle", flag(sci), 32'h0);
    wr(1'b0, 1'b0, 8'hd8, 32'h1);
    send(1'b0, id2, 4'h0);
    rd("smi status", 1'b0, 1'b0, 8'h60, '1, root(2'b01, id2));
    check("smi", flag(smi), 32'h1);
    check("smi no native", flag(native), 32'h0);
    wr(1'b0, 1'b0, 8'h60, 32'h1_0000);
    @(posedge mclk_i) #5;
    check("smi off", flag(smi), 32'h0);
    // both routes on one port: event block and smi together, no native
    wr(1'b0, 1'b1, 8'hd8, 32'h8000_0001);
    send(1'b1, id1, 4'h2);
    rd("dual status", 1'b1, 1'b0, 8'h0, 32'h2_0000, 32'h2_0000);
    check("dual sci", flag(sci), 32'h1);
    check("dual smi", flag(smi), 32'h1);
    check("dual native", flag(native), 32'h0);
    // back to native: event routing goes away before the interrupt is armed
    wr(1'b0, 1'b1, 8'hd8, 32'h0);
    check("native unarmed", flag(native), 32'h0);
    wr(1'b0, 1'b1, 8'h5c, 32'h8);
    @(posedge mclk_i) #5;
    check("native armed", flag(native), 32'h1);
    check("smi rerouted", flag(smi), 32'h0);
    wr(1'b0, 1'b1, 8'h60, 32'h1_0000);
    wr(1'b1, 1'b0, 8'h0, 32'h2_0000);
    @(posedge mclk_i) #5;
    check("native cleared", flag(native), 32'h0);
    check("sci cleared", flag(sci), 32'h0);
    complete_run();
  end
endmodule : pme_route_tb
